// *** include/crcdma_map.svh ***
// Register offsets, field positions, reset values and polynomials of the CRC DMA engine
`ifndef CRCDMA_MAP_SVH
`define CRCDMA_MAP_SVH

// ****************************************
// Register byte offsets (low seven address bits)
// ****************************************
`define CRCDMA_OFF_DESCRIPTOR_BASE_FIELD 7'h00
`define CRCDMA_OFF_DMA_EN 7'h08
`define CRCDMA_OFF_DMA_DIS 7'h0c
`define CRCDMA_OFF_DMA_SR 7'h10
`define CRCDMA_OFF_DMA_IER 7'h14
`define CRCDMA_OFF_DMA_IDR 7'h18
`define CRCDMA_OFF_DMA_IMR 7'h1c
`define CRCDMA_OFF_DMA_ISR 7'h20
`define CRCDMA_OFF_CTRL 7'h34
`define CRCDMA_OFF_MODE 7'h38
`define CRCDMA_OFF_SR 7'h3c
`define CRCDMA_OFF_IER 7'h40
`define CRCDMA_OFF_IDR 7'h44
`define CRCDMA_OFF_IMR 7'h48
`define CRCDMA_OFF_ISR 7'h4c

// ****************************************
// Descriptor layout in system memory
// ****************************************
`define CRCDMA_DESC_ADDR 32'h0000_0000
`define CRCDMA_DESC_CTRL 32'h0000_0004
`define CRCDMA_DESC_REF 32'h0000_0020
`define CRCDMA_DESCRIPTOR_BASE_FIELD_LSB 9
`define CRCDMA_CTRL_WID_LSB 24
`define CRCDMA_CTRL_IEN_BIT 27

// ****************************************
// Mode fields, command bit, reset values
// ****************************************
`define CRCDMA_MODE_EN_BIT 0
`define CRCDMA_MODE_CMP_BIT 1
`define CRCDMA_MODE_POLY_LSB 2
`define CRCDMA_MODE_DIV_LSB 4
`define CRCDMA_CMD_BIT 0
`define CRCDMA_CRC_RST 32'hffff_ffff
`define CRCDMA_REG_RST 32'h0000_0000

// ****************************************
// Polynomials in normal form, bus codes
// ****************************************
`define CRCDMA_POLY_ETH 32'h04c1_1db7
`define CRCDMA_POLY_C 32'h1edc_6f41
`define CRCDMA_POLY_16 16'h1021
`define CRCDMA_HTRANS_IDLE 2'b00
`define CRCDMA_HTRANS_NONSEQ 2'b10

`endif

// *** include/crcdma_pkg.sv ***
// Types shared by the CRC DMA engine
package crcdma_pkg;

  // One-hot sequencer states
  typedef enum logic [6:0] {
    S_IDLE  = 7'b000_0001,
    S_DADDR = 7'b000_0010,
    S_DCTRL = 7'b000_0100,
    S_DREF  = 7'b000_1000,
    S_GAP   = 7'b001_0000,
    S_READ  = 7'b010_0000,
    S_WBACK = 7'b100_0000
  } crcdma_state_t;

  // Single read width codes, equal to AHB hsize
  typedef enum logic [1:0] {
    W_BYTE = 2'b00,
    W_HALF = 2'b01,
    W_WORD = 2'b10
  } crcdma_width_t;

  // Polynomial select codes
  typedef enum logic [1:0] {
    P_ETH = 2'b00,
    P_C   = 2'b01,
    P_16  = 2'b10
  } crcdma_poly_t;

endpackage

// *** hw/crcdma_top.sv ***
// CRC calculation engine with AHB-Lite register slave and AHB-Lite read master
//
// Contract
// - width code picks byte, halfword, word reads
// - done flag set even without completion enable
// - compare result against descriptor reference word
// - enable write bit0 starts channel
// - disable write bit0 stops channel
// - channel state bit shows enabled channel
// - done mask set, cleared, read back
// - done flag set at end, cleared on read
// - control bit0 reloads running value all ones
// - mode holds enable, compare, polynomial, divider
// - mismatch under compare sets error flag
// - reads spaced by two power divider+1
// - running value hidden while compare enabled
// - error mask set, cleared, flag reported
// - count decrements, channel stops at zero
// - checksum taken LSB first from start
// - descriptor words at offsets 0, 4, 0x20
`timescale 1ns/1ps
`include "crcdma_map.svh"

module crcdma_top
  import crcdma_pkg::*;
#(
  parameter int CNT_W = 16
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  output logic [31:0] m_haddr,
  output logic [1:0] m_htrans,
  output logic [2:0] m_hsize,
  output logic m_hwrite,
  output logic [31:0] m_hwdata,
  input wire logic [31:0] m_hrdata,
  input wire logic m_hready,
  output logic irq
);

  // ****************************************
  // Register slave
  // ****************************************
  logic [6:0] s_addr_q;
  logic s_wr_q, s_rd_q, hreadyout_q;
  logic [31:0] hrdata_q;
  logic [31:0] rmux;
  logic [22:0] descriptor_base_field_q;
  logic [7:0] mode_q;
  logic active_q, dmask_q, dflag_q, emask_q, eflag_q, irq_q;
  logic [31:0] crc_q, crc_d;

  wire s_take = hsel & htrans[1] & hready;

  // Address phase capture; reads get one wait state
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_addr_q <= 7'h00;
      s_wr_q <= 1'b0;
      s_rd_q <= 1'b0;
      hreadyout_q <= 1'b1;
    end else begin
      s_addr_q <= s_take ? haddr[6:0] : s_addr_q;
      s_wr_q <= s_take & hwrite;
      s_rd_q <= s_take & ~hwrite;
      hreadyout_q <= ~(s_take & ~hwrite);
    end
  end

  // Write strobes in the data phase
  wire w_descriptor_base_field = s_wr_q && s_addr_q == `CRCDMA_OFF_DESCRIPTOR_BASE_FIELD;
  wire w_go = s_wr_q && s_addr_q == `CRCDMA_OFF_DMA_EN && hwdata[`CRCDMA_CMD_BIT];
  wire w_stop = s_wr_q && s_addr_q == `CRCDMA_OFF_DMA_DIS && hwdata[`CRCDMA_CMD_BIT];
  wire w_dier = s_wr_q && s_addr_q == `CRCDMA_OFF_DMA_IER && hwdata[`CRCDMA_CMD_BIT];
  wire w_didr = s_wr_q && s_addr_q == `CRCDMA_OFF_DMA_IDR && hwdata[`CRCDMA_CMD_BIT];
  wire w_crst = s_wr_q && s_addr_q == `CRCDMA_OFF_CTRL && hwdata[`CRCDMA_CMD_BIT];
  wire w_mode = s_wr_q && s_addr_q == `CRCDMA_OFF_MODE;
  wire w_eier = s_wr_q && s_addr_q == `CRCDMA_OFF_IER && hwdata[`CRCDMA_CMD_BIT];
  wire w_eidr = s_wr_q && s_addr_q == `CRCDMA_OFF_IDR && hwdata[`CRCDMA_CMD_BIT];
  wire r_dflag = s_rd_q && s_addr_q == `CRCDMA_OFF_DMA_ISR;
  wire r_eflag = s_rd_q && s_addr_q == `CRCDMA_OFF_ISR;

  // Mode fields
  wire crc_en = mode_q[`CRCDMA_MODE_EN_BIT];
  wire cmp_en = mode_q[`CRCDMA_MODE_CMP_BIT];
  wire [1:0] poly_sel = mode_q[`CRCDMA_MODE_POLY_LSB +: 2];
  wire [3:0] div_sel = mode_q[`CRCDMA_MODE_DIV_LSB +: 4];

  // Read data selection; unmapped words read zero
  assign rmux =
    (s_addr_q == `CRCDMA_OFF_DESCRIPTOR_BASE_FIELD) ? {descriptor_base_field_q, 9'h000} :
    (s_addr_q == `CRCDMA_OFF_DMA_SR) ? {31'h0, active_q} :
    (s_addr_q == `CRCDMA_OFF_DMA_IMR) ? {31'h0, dmask_q} :
    (s_addr_q == `CRCDMA_OFF_DMA_ISR) ? {31'h0, dflag_q} :
    (s_addr_q == `CRCDMA_OFF_MODE) ? {24'h0, mode_q} :
    (s_addr_q == `CRCDMA_OFF_SR) ? (cmp_en ? 32'h0 : crc_q) :
    (s_addr_q == `CRCDMA_OFF_IMR) ? {31'h0, emask_q} :
    (s_addr_q == `CRCDMA_OFF_ISR) ? {31'h0, eflag_q} : 32'h0;

  // Read data register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_q <= `CRCDMA_REG_RST;
    end else if (s_rd_q) begin
      hrdata_q <= rmux;
    end
  end

  // Base and mode registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      descriptor_base_field_q <= 23'h0;
      mode_q <= 8'h00;
    end else begin
      descriptor_base_field_q <= w_descriptor_base_field ? hwdata[31:`CRCDMA_DESCRIPTOR_BASE_FIELD_LSB] : descriptor_base_field_q;
      mode_q <= w_mode ? hwdata[7:0] : mode_q;
    end
  end

  // ****************************************
  // DMA sequencer
  // ****************************************
  crcdma_state_t st_q, st_d;
  logic bdata_q, bdata_d;
  logic [31:0] cur_q, cur_d, ref_q, ref_d;
  logic [CNT_W-1:0] cnt_q, cnt_d;
  logic [1:0] wid_q, wid_d;
  logic ien_q, ien_d;
  logic [16:0] gap_q, gap_d;
  logic [31:0] m_haddr_q, m_haddr_d, m_hwdata_q, m_hwdata_d;
  logic [1:0] m_htrans_q, m_htrans_d;
  logic [2:0] m_hsize_q, m_hsize_d;
  logic m_hwrite_q, m_hwrite_d;
  logic nx_issue, nx_wr, fin;
  logic [31:0] nx_addr;
  logic [2:0] nx_size;

  wire [31:0] dbase = {descriptor_base_field_q, 9'h000};
  wire beat_done = bdata_q & m_hready;
  wire addr_ack = (m_htrans_q == `CRCDMA_HTRANS_NONSEQ) & m_hready;
  wire [16:0] gap_load = 17'((17'd2 << div_sel) - 17'd1);
  wire [31:0] step = 32'(32'd1 << wid_q);
  wire [31:0] lane_data = m_hrdata >> {m_haddr_q[1:0], 3'b000};
  wire is16 = poly_sel == P_16;
  wire mismatch = is16 ? (crc_q[15:0] != ref_q[15:0]) : (crc_q != ref_q);
  wire [31:0] wb_word = {4'h0, ien_q, 1'b0, wid_q, 24'h0};

  // Reflected update of the running value, one data bit at a time
  function automatic logic [31:0] crc_step(input logic [31:0] c, input logic [31:0] d,
                                           input logic [1:0] w, input logic [1:0] p);
    logic [31:0] r;
    logic [31:0] pr;
    logic [15:0] pr16;
    logic fb;
    r = c;
    pr = {<<{`CRCDMA_POLY_ETH}};
    pr16 = {<<{`CRCDMA_POLY_16}};
    fb = 1'b0;
    if (p == P_C) begin
      pr = {<<{`CRCDMA_POLY_C}};
    end
    for (int i = 0; i < 32; i++) begin
      if (i < (8 << w)) begin
        fb = r[0] ^ d[i];
        if (p == P_16) begin
          r = {r[31:16], 1'b0, r[15:1]} ^ (fb ? {16'h0, pr16} : 32'h0);
        end else begin
          r = {1'b0, r[31:1]} ^ (fb ? pr : 32'h0);
        end
      end
    end
    return r;
  endfunction

  // Next state, bus request and running value
  always_comb begin
    st_d = st_q;
    bdata_d = bdata_q;
    cur_d = cur_q;
    ref_d = ref_q;
    cnt_d = cnt_q;
    wid_d = wid_q;
    ien_d = ien_q;
    gap_d = gap_q;
    crc_d = crc_q;
    m_haddr_d = m_haddr_q;
    m_htrans_d = m_htrans_q;
    m_hsize_d = m_hsize_q;
    m_hwrite_d = m_hwrite_q;
    m_hwdata_d = m_hwdata_q;
    nx_issue = 1'b0;
    nx_wr = 1'b0;
    nx_addr = dbase;
    nx_size = 3'd2;
    fin = 1'b0;
    if (beat_done) begin
      bdata_d = 1'b0;
    end
    if (addr_ack) begin
      m_htrans_d = `CRCDMA_HTRANS_IDLE;
      bdata_d = 1'b1;
    end
    case (st_q)
      S_IDLE: begin
        if (w_go) begin
          nx_issue = 1'b1;
          nx_addr = dbase + `CRCDMA_DESC_ADDR;
          st_d = S_DADDR;
        end
      end
      S_DADDR: begin
        if (beat_done) begin
          cur_d = m_hrdata;
          nx_issue = 1'b1;
          nx_addr = dbase + `CRCDMA_DESC_CTRL;
          st_d = S_DCTRL;
        end
      end
      S_DCTRL: begin
        if (beat_done) begin
          cnt_d = m_hrdata[CNT_W-1:0];
          wid_d = m_hrdata[`CRCDMA_CTRL_WID_LSB +: 2];
          ien_d = m_hrdata[`CRCDMA_CTRL_IEN_BIT];
          nx_issue = 1'b1;
          nx_addr = dbase + `CRCDMA_DESC_REF;
          st_d = S_DREF;
        end
      end
      S_DREF: begin
        if (beat_done) begin
          ref_d = m_hrdata;
          gap_d = gap_load;
          fin = cnt_q == '0;
          st_d = (cnt_q == '0) ? S_IDLE : S_GAP;
        end
      end
      S_GAP: begin
        if (!active_q) begin
          st_d = S_IDLE;
        end else if (gap_q == 17'h0) begin
          nx_issue = 1'b1;
          nx_addr = cur_q;
          nx_size = {1'b0, wid_q};
          st_d = S_READ;
        end else begin
          gap_d = gap_q - 17'd1;
        end
      end
      S_READ: begin
        if (beat_done) begin
          if (crc_en) begin
            crc_d = crc_step(crc_q, lane_data, wid_q, poly_sel);
          end
          cur_d = cur_q + step;
          cnt_d = cnt_q - 1'b1;
          gap_d = gap_load;
          st_d = S_GAP;
          if (cnt_q == CNT_W'(1)) begin
            nx_issue = 1'b1;
            nx_wr = 1'b1;
            nx_addr = dbase + `CRCDMA_DESC_CTRL;
            st_d = S_WBACK;
          end
        end
      end
      S_WBACK: begin
        if (beat_done) begin
          fin = 1'b1;
          st_d = S_IDLE;
        end
      end
      default: begin
        st_d = S_IDLE;
      end
    endcase
    if (nx_issue) begin
      m_htrans_d = `CRCDMA_HTRANS_NONSEQ;
      m_haddr_d = nx_addr;
      m_hsize_d = nx_size;
      m_hwrite_d = nx_wr;
      m_hwdata_d = wb_word;
    end
    if (w_crst) begin
      crc_d = `CRCDMA_CRC_RST;
    end
  end

  // Sequencer and master registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_q <= S_IDLE;
      bdata_q <= 1'b0;
      cur_q <= 32'h0;
      ref_q <= 32'h0;
      cnt_q <= '0;
      wid_q <= 2'b00;
      ien_q <= 1'b0;
      gap_q <= 17'h0;
      crc_q <= `CRCDMA_CRC_RST;
      m_haddr_q <= 32'h0;
      m_htrans_q <= `CRCDMA_HTRANS_IDLE;
      m_hsize_q <= 3'd0;
      m_hwrite_q <= 1'b0;
      m_hwdata_q <= 32'h0;
    end else begin
      st_q <= st_d;
      bdata_q <= bdata_d;
      cur_q <= cur_d;
      ref_q <= ref_d;
      cnt_q <= cnt_d;
      wid_q <= wid_d;
      ien_q <= ien_d;
      gap_q <= gap_d;
      crc_q <= crc_d;
      m_haddr_q <= m_haddr_d;
      m_htrans_q <= m_htrans_d;
      m_hsize_q <= m_hsize_d;
      m_hwrite_q <= m_hwrite_d;
      m_hwdata_q <= m_hwdata_d;
    end
  end

  // ****************************************
  // Channel state, masks, flags, interrupt
  // ****************************************
  wire err_ev = fin & cmp_en;
  wire irq_d = (dflag_q & dmask_q & ien_q) | (eflag_q & emask_q);

  // Flags: a new event wins over the clear by read
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      active_q <= 1'b0;
      dmask_q <= 1'b0;
      dflag_q <= 1'b0;
      emask_q <= 1'b0;
      eflag_q <= 1'b0;
      irq_q <= 1'b0;
    end else begin
      active_q <= ~(w_stop | fin) & (active_q | (w_go & st_q == S_IDLE));
      dmask_q <= w_dier | (dmask_q & ~w_didr);
      dflag_q <= fin | (dflag_q & ~r_dflag);
      emask_q <= w_eier | (emask_q & ~w_eidr);
      eflag_q <= (err_ev & mismatch) | (eflag_q & ~r_eflag);
      irq_q <= irq_d;
    end
  end

  assign hreadyout = hreadyout_q;
  assign hrdata = hrdata_q;
  assign hresp = 1'b0;
  assign m_haddr = m_haddr_q;
  assign m_htrans = m_htrans_q;
  assign m_hsize = m_hsize_q;
  assign m_hwrite = m_hwrite_q;
  assign m_hwdata = m_hwdata_q;
  assign irq = irq_q;

  // ****************************************
  // Assertions
  // ****************************************
  default clocking dclk @(posedge hclk); endclocking
  default disable iff (!hresetn);

  sequence start_seq;
    st_q == S_IDLE && w_go;
  endsequence

  sequence read_beat_seq;
    st_q == S_READ && beat_done;
  endsequence

  go_starts_channel_a: assert property (start_seq |=> active_q && st_q == S_DADDR)
    else $error("enable write did not start the channel");
  stop_clears_state_a: assert property (w_stop |=> !active_q)
    else $error("disable write left the channel enabled");
  state_bit_read_a: assert property (
    s_rd_q && s_addr_q == `CRCDMA_OFF_DMA_SR |=> hrdata_q[0] == $past(active_q))
    else $error("channel state bit read wrong");
  desc_fetch_addr_a: assert property (
    start_seq |=> m_htrans_q == `CRCDMA_HTRANS_NONSEQ && m_haddr_q == $past(dbase))
    else $error("descriptor fetch address wrong");
  read_width_a: assert property (
    st_q == S_READ && m_htrans_q == `CRCDMA_HTRANS_NONSEQ |-> m_hsize_q == {1'b0, wid_q})
    else $error("single read size does not follow width code");
  count_down_a: assert property (read_beat_seq |=> cnt_q == $past(cnt_q) - 1'b1)
    else $error("transfer count not decremented");
  gap_hold_a: assert property (
    st_q == S_GAP && gap_q != 17'h0 && active_q |=> st_q == S_GAP && gap_q == $past(gap_q) - 1)
    else $error("read issued before divider gap elapsed");
  done_flag_a: assert property (fin |=> dflag_q && !active_q)
    else $error("done flag not set at end of transfer");
  done_read_clear_a: assert property (r_dflag && !fin |=> !dflag_q)
    else $error("done flag not cleared by read");
  mask_update_a: assert property (w_dier |=> dmask_q)
    else $error("done mask not set by enable write");
  crc_reload_a: assert property (w_crst |=> crc_q == `CRCDMA_CRC_RST)
    else $error("running value not reloaded");
  crc_hidden_a: assert property (
    s_rd_q && s_addr_q == `CRCDMA_OFF_SR && cmp_en |=> hrdata_q == 32'h0)
    else $error("running value readable under compare");
  mismatch_flag_a: assert property (fin && cmp_en && mismatch |=> eflag_q)
    else $error("mismatch did not set error flag");
  err_mask_a: assert property (w_eier ##1 !w_eidr [*2] |-> emask_q)
    else $error("error mask not held after enable write");
  irq_gate_a: assert property (##1 irq_q == $past(irq_d))
    else $error("interrupt line not gated by flag and mask");

endmodule // crcdma_top

// *** dv/crcdma_mem.sv ***
// System memory model answering the engine's AHB-Lite read master
`timescale 1ns/1ps

module crcdma_mem (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic [31:0] m_haddr,
  input wire logic [1:0] m_htrans,
  input wire logic m_hwrite,
  input wire logic [31:0] m_hwdata,
  output logic [31:0] m_hrdata,
  output logic m_hready,
  input wire logic [3:0] waits
);
  logic [31:0] mem [0:1023];
  logic [31:0] a_q;
  logic [31:0] last_q;
  logic ph_q;
  logic wr_q;
  logic [3:0] cnt_q;

  // Ready once the wait count of the open data phase runs out
  assign m_hready = !ph_q || cnt_q == 4'h0;
  // Data only in the last data cycle, else a toggling pattern
  assign m_hrdata = (ph_q && cnt_q == 4'h0 && !wr_q) ? mem[a_q[11:2]] : ~last_q;

  // Address capture, wait states, control word writeback
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ph_q <= 1'b0;
      cnt_q <= 4'h0;
      last_q <= 32'h0;
    end else begin
      last_q <= m_hrdata;
      if (ph_q && m_hready) begin
        ph_q <= 1'b0;
        if (wr_q) mem[a_q[11:2]] <= m_hwdata;
      end else if (ph_q) begin
        cnt_q <= cnt_q - 4'h1;
      end
      if (m_hready && m_htrans[1]) begin
        ph_q <= 1'b1;
        a_q <= m_haddr;
        wr_q <= m_hwrite;
        cnt_q <= waits;
      end
    end
  end
endmodule // crcdma_mem

// *** dv/tb_crcdma_top.sv ***
// Self-checking bench for the CRC DMA engine
`timescale 1ns/1ps
`include "crcdma_map.svh"

module tb_crcdma_top;
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, m_hwrite, m_hready, irq, dmask;
  logic [31:0] haddr, hwdata, hrdata, m_haddr, m_hwdata, m_hrdata, rd;
  logic [1:0] htrans, m_htrans;
  logic [2:0] hsize, m_hsize;
  logic [3:0] waits;
  logic [31:0] adr_q[$];
  logic [2:0] sz_q[$];
  int cyc_q[$];
  int bad_count, num_checks, cyc, s;

  crcdma_top #(.CNT_W(16)) dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .m_haddr(m_haddr),
    .m_htrans(m_htrans), .m_hsize(m_hsize), .m_hwrite(m_hwrite), .m_hwdata(m_hwdata),
    .m_hrdata(m_hrdata), .m_hready(m_hready), .irq(irq));
  crcdma_mem u_mem (.hclk(hclk), .hresetn(hresetn), .m_haddr(m_haddr), .m_htrans(m_htrans),
    .m_hwrite(m_hwrite), .m_hwdata(m_hwdata), .m_hrdata(m_hrdata), .m_hready(m_hready),
    .waits(waits));

  // ********
  // Clock, master monitor, watchdog
  // ********
  initial begin
    hclk = 1'b0;
    forever #50 hclk = ~hclk;
  end
  // Log every master request taken by memory
  always @(posedge hclk) begin
    cyc <= cyc + 1;
    if (m_htrans[1] && m_hready) begin
      adr_q.push_back(m_haddr);
      sz_q.push_back(m_hsize);
      cyc_q.push_back(cyc);
    end
  end
  // Cut a hang short
  initial begin
    repeat (30000) @(posedge hclk);
    bad_count++;
    end_of_test();
  end

  // ********
  // Tasks and reference model
  // ********
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  // One single transfer, each phase held until hready is high
  task automatic bus(input logic w, input logic [6:0] off, input logic [31:0] wd);
    haddr <= {25'h0, off};
    hwrite <= w;
    htrans <= `CRCDMA_HTRANS_NONSEQ;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= `CRCDMA_HTRANS_IDLE;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  task automatic rchk(input string nm, input logic [6:0] off, input logic [31:0] e);
    bus(1'b0, off, 32'h0);
    chk(nm, e, rd);
  endtask
  // Reflected LSB-first byte update, 16-bit variant on low half
  function automatic logic [31:0] crc_upd(input logic [31:0] c, input logic [7:0] d,
                                          input logic [1:0] p);
    logic [31:0] pl;
    logic [31:0] rp;
    logic [31:0] x;
    pl = p == 2'd1 ? `CRCDMA_POLY_C : `CRCDMA_POLY_ETH;
    if (p == 2'd2) pl = {`CRCDMA_POLY_16, 16'h0};
    for (int i = 0; i < 32; i++) rp[i] = pl[31 - i];
    x = (p == 2'd2) ? {16'h0, c[15:0]} : c;
    x = x ^ {24'h0, d};
    for (int i = 0; i < 8; i++) x = x[0] ? (x >> 1) ^ rp : x >> 1;
    return (p == 2'd2) ? {c[31:16], x[15:0]} : x;
  endfunction
  function automatic logic [31:0] exp_crc(input logic [1:0] w, input logic [1:0] p, input int n);
    logic [31:0] c;
    logic [11:0] a;
    c = `CRCDMA_CRC_RST;
    for (int k = 0; k < (n << w); k++) begin
      a = 12'h100 + 12'(k);
      c = crc_upd(c, 8'(u_mem.mem[a[11:2]] >> (8 * a[1:0])), p);
    end
    return c;
  endfunction
  // Load a descriptor, start the channel, check the whole pass
  task automatic run(input logic [1:0] w, input logic [1:0] p, input logic [3:0] dv,
                     input int n, input logic completion_irq_enable, input logic cmp, input logic bad);
    logic [31:0] e;
    e = exp_crc(w, p, n);
    u_mem.mem[128] = 32'h100;
    u_mem.mem[129] = {4'h0, completion_irq_enable, 1'b0, w, 8'h0, 16'(n)};
    u_mem.mem[136] = bad ? ~e : e;
    bus(1'b1, `CRCDMA_OFF_MODE, 32'h1);
    bus(1'b1, `CRCDMA_OFF_CTRL, 32'h1);
    bus(1'b1, `CRCDMA_OFF_DESCRIPTOR_BASE_FIELD, 32'h200);
    bus(1'b1, `CRCDMA_OFF_MODE, {24'h0, dv, p, cmp, 1'b1});
    s = adr_q.size();
    bus(1'b1, `CRCDMA_OFF_DMA_EN, 32'h1);
    rchk("chan_on", `CRCDMA_OFF_DMA_SR, 32'h1);
    do bus(1'b0, `CRCDMA_OFF_DMA_SR, 32'h0); while (rd[0] !== 1'b0);
    chk("irq", {31'h0, (completion_irq_enable & dmask) | (cmp & bad)}, {31'h0, irq});
    rchk("crc", `CRCDMA_OFF_SR, cmp ? 32'h0 : e);
    rchk("done", `CRCDMA_OFF_DMA_ISR, 32'h1);
    rchk("done_clr", `CRCDMA_OFF_DMA_ISR, 32'h0);
    rchk("err", `CRCDMA_OFF_ISR, {31'h0, cmp & bad});
    repeat (2) @(posedge hclk);
    chk("irq_off", 32'h0, {31'h0, irq});
    chk("count", {4'h0, completion_irq_enable, 1'b0, w, 24'h0}, u_mem.mem[129]);
    chk("d0", 32'h200, adr_q[s]);
    chk("d4", 32'h204, adr_q[s + 1]);
    chk("d20", 32'h220, adr_q[s + 2]);
    for (int k = 0; k < n; k++) begin
      chk("adr", 32'h100 + (32'(k) << w), adr_q[s + 3 + k]);
      chk("size", {1'b0, w}, sz_q[s + 3 + k]);
      chk("gap", 1, cyc_q[s + 3 + k] - cyc_q[s + 2 + k] >= (2 << dv) + 2);
    end
    chk("wback", 32'h204, adr_q[s + 3 + n]);
    chk("reads", s + 4 + n, adr_q.size());
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // ********
  // Main sequence
  // ********
  initial begin
    hresetn = 1'b0;
    hsel = 1'b1;
    haddr = 32'h0;
    htrans = `CRCDMA_HTRANS_IDLE;
    hwrite = 1'b0;
    hsize = 3'b010;
    hwdata = 32'h0;
    waits = 4'h0;
    dmask = 1'b1;
    for (int i = 0; i < 1024; i++) u_mem.mem[i] = 32'h9e37_79b9 * i + 32'h1234_5677;
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    rchk("descriptor_base_field_rst", `CRCDMA_OFF_DESCRIPTOR_BASE_FIELD, 32'h0);
    rchk("dsr_rst", `CRCDMA_OFF_DMA_SR, 32'h0);
    rchk("dimr_rst", `CRCDMA_OFF_DMA_IMR, 32'h0);
    rchk("disr_rst", `CRCDMA_OFF_DMA_ISR, 32'h0);
    rchk("mode_rst", `CRCDMA_OFF_MODE, 32'h0);
    rchk("sr_rst", `CRCDMA_OFF_SR, `CRCDMA_CRC_RST);
    rchk("eimr_rst", `CRCDMA_OFF_IMR, 32'h0);
    rchk("eisr_rst", `CRCDMA_OFF_ISR, 32'h0);
    chk("hresp", 32'h0, {31'h0, hresp});
    bus(1'b1, 7'h24, 32'hffff_ffff);
    rchk("unmapped", 7'h24, 32'h0);
    bus(1'b1, `CRCDMA_OFF_DESCRIPTOR_BASE_FIELD, 32'hffff_ffff);
    rchk("descriptor_base_field", `CRCDMA_OFF_DESCRIPTOR_BASE_FIELD, 32'hffff_fe00);
    bus(1'b1, `CRCDMA_OFF_MODE, 32'hffff_ffff);
    rchk("mode", `CRCDMA_OFF_MODE, 32'h0000_00ff);
    rchk("sr_hidden", `CRCDMA_OFF_SR, 32'h0);
    bus(1'b1, `CRCDMA_OFF_DMA_EN, 32'h0);
    rchk("en_zero", `CRCDMA_OFF_DMA_SR, 32'h0);
    bus(1'b1, `CRCDMA_OFF_DMA_IER, 32'h1);
    rchk("dimr_set", `CRCDMA_OFF_DMA_IMR, 32'h1);
    bus(1'b1, `CRCDMA_OFF_DMA_IDR, 32'h1);
    rchk("dimr_clr", `CRCDMA_OFF_DMA_IMR, 32'h0);
    bus(1'b1, `CRCDMA_OFF_IER, 32'h1);
    rchk("eimr_set", `CRCDMA_OFF_IMR, 32'h1);
    bus(1'b1, `CRCDMA_OFF_IDR, 32'h1);
    rchk("eimr_clr", `CRCDMA_OFF_IMR, 32'h0);
    bus(1'b1, `CRCDMA_OFF_IER, 32'h1);
    bus(1'b1, `CRCDMA_OFF_DMA_IER, 32'h1);
    run(2'd0, 2'd0, 4'd0, 3, 1'b0, 1'b0, 1'b0);
    run(2'd1, 2'd1, 4'd1, 2, 1'b1, 1'b0, 1'b0);
    run(2'd2, 2'd2, 4'd2, 2, 1'b1, 1'b0, 1'b0);
    run(2'd0, 2'd3, 4'd0, 2, 1'b0, 1'b0, 1'b0);
    run(2'd2, 2'd0, 4'd0, 2, 1'b0, 1'b1, 1'b0);
    run(2'd2, 2'd0, 4'd0, 2, 1'b0, 1'b1, 1'b1);
    waits <= 4'h2;
    dmask = 1'b0;
    bus(1'b1, `CRCDMA_OFF_DMA_IDR, 32'h1);
    run(2'd1, 2'd0, 4'd0, 3, 1'b1, 1'b0, 1'b0);
    bus(1'b1, `CRCDMA_OFF_CTRL, 32'h1);
    rchk("sr_reload", `CRCDMA_OFF_SR, `CRCDMA_CRC_RST);
    u_mem.mem[129] = 32'h0000_0032;
    bus(1'b1, `CRCDMA_OFF_DMA_EN, 32'h1);
    repeat (30) @(posedge hclk);
    bus(1'b1, `CRCDMA_OFF_DMA_DIS, 32'h1);
    rchk("chan_off", `CRCDMA_OFF_DMA_SR, 32'h0);
    repeat (20) @(posedge hclk);
    s = adr_q.size();
    repeat (40) @(posedge hclk);
    chk("stopped", s, adr_q.size());
    end_of_test();
  end
endmodule // tb_crcdma_top
